/* File: kpm_pkg.sv */
// Purpose: Shared constants for the private key entry manage decoder
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes: Status codes and field positions are named once here
package kpm_pkg;
    // ======================================================
    // Command framing
    localparam logic [7:0] CMD_CODE = 8'h46;
    localparam logic [7:0] ACT_GEN = 8'h00;
    localparam logic [7:0] ACT_IMPORT = 8'h01;
    localparam logic [7:0] ACT_META = 8'h02;
    localparam logic [7:0] CURVE_A = 8'h0c;
    localparam logic [7:0] CURVE_B = 8'h0d;
    localparam logic [2:0] SLOT_MAX = 3'h4;
    localparam logic [7:0] HDR_LEN = 8'h0b;
    localparam logic [7:0] IMPORT_LEN = 8'h2b;
    localparam logic [7:0] PUBKEY_LEN = 8'h41;
    localparam logic [7:0] PUBKEY_LEAD = 8'h04;
    // ======================================================
    // Field layouts
    localparam logic [7:0] SLOT_RSV_MASK = 8'hf8;
    localparam logic [15:0] POL_RSV_MASK = 16'h7ec3;
    localparam int POL_FREEZE = 15;
    localparam int POL_AUTH = 8;
    localparam int POL_SDM = 5;
    localparam int POL_SIGN = 4;
    localparam int POL_DH = 3;
    localparam int POL_SIGMA = 2;
    localparam logic [15:0] POL_SIGNTYPE = 16'h0134;
    localparam logic [7:0] UPD_RSV_MASK = 8'hc0;
    // ======================================================
    // Status words (second byte)
    localparam logic [7:0] ST_HIGH = 8'h91;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_PARAM = 8'h9e;
    localparam logic [7:0] ST_LENGTH = 8'h7e;
    localparam logic [7:0] ST_DENIED = 8'h9d;
    localparam logic [7:0] ST_NOKEY = 8'h40;
    localparam logic [7:0] ST_FULL = 8'h0e;
    // ======================================================
    // Register byte addresses
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_RESP = 8'h0c;
    localparam logic [7:0] A_IRQ = 8'h10;
    localparam logic [7:0] A_MASK = 8'h14;
    localparam logic [7:0] A_PERM = 8'h18;
    localparam logic [7:0] A_PUB = 8'h1c;
    localparam logic [7:0] A_FREE = 8'h20;
    // ======================================================
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_OVF = 2;
endpackage : kpm_pkg

/* File: private_key_entry_manage.sv */
// Purpose: Decode and check the private key entry manage command
// Assumes: Host pushes command bytes one per APB write; crypto is outside
// Notes: Slot table lives here; crypto and key storage sit outside
// Summary of operation
// (R1) First byte 0x46, then key slot byte
// (R2) Slot bits 7:3 zero, slots 0 to 4
// (R3) Action 0,1,2; import carries 32 key bytes
// (R4) Generate returns 65-byte key, lead 0x04
// (R5) Policy freeze, SIGMA bit, reserved bits zero
// (R6) Policy bit 8 gates self authentication
// (R7) Policy bit 5 gates secure dynamic messaging
// (R8) Policy bit 4 gates signing action 0x03
// (R9) Policy bit 3 gates key agreement 0x05
// (R10) Protection byte bits 7:6 zero, 5:4 mode
// (R11) Access condition bits 3:0 any value
// (R12) Four-byte limit, LSB first, zero disables
// (R13) DH with signing bits denied 0x9d
// (R14) Frozen limit change or unfreeze denied
// (R15) Empty slot 0x40; other curve 0x9d
// (R16) No free memory on create gives 0x0e
// (R17) Bad reserved, code or length: parameter error; a bad length gives 0x7e here
`timescale 1ns/1ps
`default_nettype none
module private_key_entry_manage (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pubkey_byte,
    input wire logic mem_free,
    output logic irq
);
    // Assertion defaults; the block has a single clock domain
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ======================================================
    // Bus decode
    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ======================================================
    // Per-slot storage
    logic [4:0] used_r;
    logic [7:0] curve_r [0:4];
    logic [15:0] pol_r [0:4];
    logic [7:0] prot_r [0:4];
    logic [31:0] lim_r [0:4];

    // Command capture state
    logic [7:0] cnt_r;
    logic [7:0] hdr_r [0:10];
    logic busy_r;
    logic [7:0] status_r;
    logic [7:0] pub_idx_r;
    logic [2:0] irq_st_r, irq_mask_r;
    logic [4:0] perm_slot_r;
    logic [2:0] perm_kind_r;

    logic push, start, fin;
    assign push = wr && paddr == kpm_pkg::A_CMD;
    assign start = wr && paddr == kpm_pkg::A_CTRL && pwdata[0];

    // Named header fields
    logic [7:0] slot_b, act_b, crv_b, upd_b;
    logic [15:0] pol_w;
    logic [31:0] lim_w;
    logic [2:0] sl;
    assign slot_b = hdr_r[1];
    assign act_b = hdr_r[2];
    assign crv_b = hdr_r[3];
    assign pol_w = {hdr_r[5], hdr_r[4]};
    assign upd_b = hdr_r[6];
    assign lim_w = {hdr_r[10], hdr_r[9], hdr_r[8], hdr_r[7]}; // see (R12)
    assign sl = slot_b[2:0];

    // ======================================================
    // Byte collector; bytes beyond the header only counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else if (fin) begin
            cnt_r <= 8'h00;
        end else if (push && cnt_r != 8'hff) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_hdr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hdr_r[gi] <= 8'h00;
                end else if (push && cnt_r == 8'(gi)) begin
                    hdr_r[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // ======================================================
    // Validation, priority: length/param, then DH policy, then slot state
    logic [7:0] chk;
    logic [7:0] want_len;
    always_comb begin
        want_len = (act_b == kpm_pkg::ACT_IMPORT) ? kpm_pkg::IMPORT_LEN
                                                  : kpm_pkg::HDR_LEN;
        chk = kpm_pkg::ST_OK;
        if (cnt_r != want_len) begin // see (R3) (R17)
            chk = kpm_pkg::ST_LENGTH;
        end else if (hdr_r[0] != kpm_pkg::CMD_CODE) begin // see (R1)
            chk = kpm_pkg::ST_PARAM;
        end else if ((slot_b & kpm_pkg::SLOT_RSV_MASK) != 8'h00
                     || sl > kpm_pkg::SLOT_MAX) begin // see (R2) (R17)
            chk = kpm_pkg::ST_PARAM;
        end else if (act_b > kpm_pkg::ACT_META) begin // see (R3)
            chk = kpm_pkg::ST_PARAM;
        end else if (crv_b != kpm_pkg::CURVE_A
                     && crv_b != kpm_pkg::CURVE_B) begin // see (R17)
            chk = kpm_pkg::ST_PARAM;
        end else if ((pol_w & kpm_pkg::POL_RSV_MASK) != 16'h0000) begin
            chk = kpm_pkg::ST_PARAM; // see (R5)
        end else if ((upd_b & kpm_pkg::UPD_RSV_MASK) != 8'h00) begin
            chk = kpm_pkg::ST_PARAM; // see (R10) (R11)
        end else if (pol_w[kpm_pkg::POL_DH]
                     && (pol_w & kpm_pkg::POL_SIGNTYPE) != 16'h0000) begin
            chk = kpm_pkg::ST_DENIED; // see (R13)
        end else if (act_b == kpm_pkg::ACT_META) begin
            if (!used_r[sl]) begin
                chk = kpm_pkg::ST_NOKEY; // see (R15)
            end else if (crv_b != curve_r[sl]) begin
                chk = kpm_pkg::ST_DENIED; // see (R15)
            end else if (pol_r[sl][kpm_pkg::POL_FREEZE]
                         && (!pol_w[kpm_pkg::POL_FREEZE]
                             || lim_w != lim_r[sl])) begin
                chk = kpm_pkg::ST_DENIED; // see (R14)
            end
        end else if (!used_r[sl] && !mem_free) begin
            chk = kpm_pkg::ST_FULL; // see (R16)
        end
    end
    assign fin = start && !busy_r;

    // ======================================================
    // Slot update only on a clean command
    logic commit;
    assign commit = fin && chk == kpm_pkg::ST_OK;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    used_r[gi] <= 1'b0;
                    curve_r[gi] <= 8'h00;
                    pol_r[gi] <= 16'h0000;
                    prot_r[gi] <= 8'h00;
                    lim_r[gi] <= 32'h0000_0000;
                end else if (commit && sl == 3'(gi)) begin
                    used_r[gi] <= 1'b1; // see (R16)
                    curve_r[gi] <= crv_b;
                    pol_r[gi] <= pol_w;
                    prot_r[gi] <= upd_b; // see (R10) (R11)
                    lim_r[gi] <= lim_w; // see (R12)
                end
            end
        end
    endgenerate

    // ======================================================
    // Status word and public key stream; generate streams 65 bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= kpm_pkg::ST_OK;
            busy_r <= 1'b0;
            pub_idx_r <= 8'h00;
        end else if (fin) begin
            status_r <= chk;
            busy_r <= commit && act_b == kpm_pkg::ACT_GEN; // see (R4)
            pub_idx_r <= 8'h00;
        end else if (busy_r && rd && paddr == kpm_pkg::A_PUB) begin
            pub_idx_r <= pub_idx_r + 8'h01;
            if (pub_idx_r == kpm_pkg::PUBKEY_LEN - 8'h01) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Lead byte is fixed; coordinates come from the crypto engine
    logic [7:0] pub_out;
    assign pub_out = (pub_idx_r == 8'h00) ? kpm_pkg::PUBKEY_LEAD
                                          : pubkey_byte; // see (R4)

    // ======================================================
    // Use permission lookup for the other command paths
    logic perm_ok;
    logic [15:0] perm_pol;
    // Stored policy of the slot asked about, from slot bits 2:0; slots 5 to 7 masked below
    assign perm_pol = pol_r[perm_slot_r[2:0]];
    always_comb begin
        case (perm_kind_r)
            3'h0: perm_ok = perm_pol[kpm_pkg::POL_AUTH]; // see (R6)
            3'h1: perm_ok = perm_pol[kpm_pkg::POL_SDM]; // see (R7)
            3'h2: perm_ok = perm_pol[kpm_pkg::POL_SIGN]; // see (R8)
            3'h3: perm_ok = perm_pol[kpm_pkg::POL_DH]; // see (R9)
            3'h4: perm_ok = perm_pol[kpm_pkg::POL_SIGMA];
            default: perm_ok = 1'b0;
        endcase
        if (perm_slot_r[2:0] > kpm_pkg::SLOT_MAX
            || !used_r[perm_slot_r[2:0]]) begin
            perm_ok = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perm_slot_r <= 5'h00;
            perm_kind_r <= 3'h0;
        end else if (wr && paddr == kpm_pkg::A_PERM) begin
            perm_slot_r <= pwdata[4:0];
            perm_kind_r <= pwdata[10:8];
        end
    end

    // ======================================================
    // Interrupts: set beats write-one-to-clear
    logic [2:0] ev;
    assign ev = {push && cnt_r == 8'hff, fin && chk != kpm_pkg::ST_OK, fin};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r <= 3'h0;
        end else begin
            irq_st_r <= (irq_st_r & ~((wr && paddr == kpm_pkg::A_IRQ)
                         ? pwdata[2:0] : 3'h0)) | ev;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= 3'h0;
        end else if (wr && paddr == kpm_pkg::A_MASK) begin
            irq_mask_r <= pwdata[2:0];
        end
    end
    assign irq = |(irq_st_r & irq_mask_r);

    // ======================================================
    // Read mux, unmapped reads zero
    always_comb begin
        case (paddr)
            kpm_pkg::A_CTRL: prdata = {31'h0, busy_r};
            kpm_pkg::A_STAT: prdata = {16'h0, kpm_pkg::ST_HIGH, status_r};
            kpm_pkg::A_RESP: prdata = {24'h0, cnt_r};
            kpm_pkg::A_IRQ: prdata = {29'h0, irq_st_r};
            kpm_pkg::A_MASK: prdata = {29'h0, irq_mask_r};
            kpm_pkg::A_PERM: prdata = {31'h0, perm_ok};
            kpm_pkg::A_PUB: prdata = {24'h0, busy_r ? pub_out : 8'h00};
            kpm_pkg::A_FREE: prdata = {27'h0, used_r};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ======================================================
    // Checks
    // Execute restarts the byte count, except while a key stream is busy
    cmd_clear_a: assert property ( // see (R1)
        fin |=> cnt_r == 8'h00)
        else $error("count not cleared");
    // Key agreement together with signing never succeeds
    dh_sign_a: assert property ( // see (R13)
        fin && cnt_r == kpm_pkg::HDR_LEN
        && hdr_r[0] == kpm_pkg::CMD_CODE
        && pol_w[kpm_pkg::POL_DH] && pol_w[kpm_pkg::POL_SIGN]
        && (pol_w & kpm_pkg::POL_RSV_MASK) == 16'h0000
        && act_b == kpm_pkg::ACT_GEN
        |=> status_r != kpm_pkg::ST_OK)
        else $error("key agreement with signing accepted");
    // Metadata only lands on an occupied slot
    nokey_meta_a: assert property ( // see (R15)
        commit && act_b == kpm_pkg::ACT_META |-> used_r[sl])
        else $error("meta on empty slot");
    // No new entry appears while memory is full
    mem_full_a: assert property ( // see (R16)
        fin && !mem_free && !used_r[sl] |=> !$rose(used_r[sl]))
        else $error("slot made while full");
    // Only metadata updates are held to a frozen limit
    frozen_limit_a: assert property ( // see (R14)
        commit && act_b == kpm_pkg::ACT_META && used_r[sl]
        && pol_r[sl][kpm_pkg::POL_FREEZE]
        |-> pol_w[kpm_pkg::POL_FREEZE] && lim_w == lim_r[sl])
        else $error("frozen limit changed");
    // First key byte read over the bus is the fixed lead
    pub_lead_a: assert property ( // see (R4)
        busy_r && pub_idx_r == 8'h00 && rd && paddr == kpm_pkg::A_PUB
        |-> prdata[7:0] == kpm_pkg::PUBKEY_LEAD)
        else $error("bad lead byte");
    // Reserved slot bits block every commit
    slot_rsv_a: assert property ( // see (R2)
        (slot_b & kpm_pkg::SLOT_RSV_MASK) != 8'h00 |-> !commit)
        else $error("reserved slot bits");
    // Import commits only with its key bytes present
    import_len_a: assert property ( // see (R3)
        commit |-> act_b != kpm_pkg::ACT_IMPORT
        || cnt_r == kpm_pkg::IMPORT_LEN)
        else $error("import length");
    // An event always lands in status, even under a clear
    irq_set_a: assert property (
        ev != 3'h0 |=> (irq_st_r & $past(ev)) == $past(ev))
        else $error("interrupt event lost");
    // Key stream ends after the last of its bytes
    busy_end_a: assert property ( // see (R4)
        busy_r && rd && paddr == kpm_pkg::A_PUB && !fin
        && pub_idx_r == kpm_pkg::PUBKEY_LEN - 8'h01 |=> !busy_r)
        else $error("key stream did not end");
endmodule : private_key_entry_manage
`default_nettype wire

/* File: key_engine_model.sv */
// Purpose: Public key engine stand-in that feeds the decoder
// Assumes: One key window read per APB access, no wait states
// Notes: A fixed byte pattern lets the bench predict every byte
`timescale 1ns/1ps
`default_nettype none
module key_engine_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    output logic [7:0] pubkey_byte
);
    // ======================================================
    // Byte index follows the host's reads of the key window
    logic [6:0] idx_r;
    logic rd_pub;
    assign rd_pub = psel && penable && !pwrite && paddr == kpm_pkg::A_PUB;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 7'h00;
        end else if (rd_pub) begin
            idx_r <= (idx_r == 7'h40) ? 7'h00 : idx_r + 7'h01;
        end
    end
    // Pattern changes every byte, so a skipped byte shows
    assign pubkey_byte = 8'h5a ^ {1'b0, idx_r};
endmodule : key_engine_model
`default_nettype wire

/* File: key_pair_manage_cmd_test.sv */
// Purpose: Self-checking bench for the key entry manage decoder
// Assumes: Zero-wait APB slave; engine model supplies key bytes
// Notes: Every successful generate is drained before the next command
`timescale 1ns/1ps
`default_nettype none
module key_pair_manage_cmd_test;
    // ======================================================
    // Signals and counters
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic mem_free, irq;
    logic [7:0] paddr, pubkey_byte;
    logic [31:0] pwdata, prdata;
    integer failures = 0;
    integer num_checks = 0;
    typedef logic [7:0] bq_t[$];
    private_key_entry_manage i_private_key_entry_manage (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pubkey_byte(pubkey_byte), .mem_free(mem_free),
        .irq(irq));
    key_engine_model i_key_engine_model (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pubkey_byte(pubkey_byte));
    // ======================================================
    // Shared tasks
    task automatic complete_run();
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One transfer, then an idle edge so no signal is driven twice
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic bq_t hdr(input logic [7:0] slot, input logic [7:0] act,
        input logic [7:0] cur, input logic [15:0] pol, input logic [7:0] prot,
        input logic [31:0] lim);
        return {8'h46, slot, act, cur, pol[7:0], pol[15:8], prot,
            lim[7:0], lim[15:8], lim[23:16], lim[31:24]};
    endfunction : hdr
    // Push the bytes, execute, compare the status word
    task automatic run(input bq_t b, input logic [7:0] st);
        logic [31:0] r;
        foreach (b[i]) apb(1'b1, kpm_pkg::A_CMD, {24'h0, b[i]}, r);
        apb(1'b1, kpm_pkg::A_CTRL, 32'h1, r);
        apb(1'b0, kpm_pkg::A_STAT, 32'h0, r);
        check(r[15:0], {8'h91, st});
    endtask : run
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r & 32'h1f, exp);
    endtask : rd
    task automatic drain();
        logic [31:0] r;
        apb(1'b0, kpm_pkg::A_PUB, 32'h0, r);
        check(r[7:0], 8'h04);
        for (int k = 1; k < 65; k++) begin
            apb(1'b0, kpm_pkg::A_PUB, 32'h0, r);
            check(r[7:0], 8'h5a ^ 8'(k));
        end
        rd(kpm_pkg::A_CTRL, 32'h0);
    endtask : drain
    // Permission per use kind: auth, sdm, sign, dh, sigma
    task automatic perm(input logic [4:0] slot, input logic [4:0] exp);
        logic [31:0] r;
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, kpm_pkg::A_PERM, {21'h0, 3'(k), 3'h0, slot}, r);
            apb(1'b0, kpm_pkg::A_PERM, 32'h0, r);
            check(r[0], exp[k]);
        end
    endtask : perm
    // ======================================================
    // Scenarios
    task automatic t_gen();
        logic [31:0] r;
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0134, 8'h0, 0), 8'h00);
        drain();
        rd(kpm_pkg::A_FREE, 32'h01);
        perm(5'h0, 5'b10111);
        rd(kpm_pkg::A_IRQ, 32'h01);
        apb(1'b1, kpm_pkg::A_MASK, 32'h1, r);
        check(irq, 1'b1);
        apb(1'b1, kpm_pkg::A_MASK, 32'h0, r);
        check(irq, 1'b0);
        apb(1'b1, kpm_pkg::A_MASK, 32'h1, r);
        apb(1'b1, kpm_pkg::A_IRQ, 32'h7, r);
        check(irq, 1'b0);
        run(hdr(8'h2, 8'h0, 8'h0c, 16'h0008, 8'h0, 0), 8'h00);
        drain();
        perm(5'h2, 5'b01000);
    endtask : t_gen
    task automatic t_bad();
        bq_t b;
        run(hdr(8'h08, 8'h0, 8'h0c, 16'h0, 8'h0, 0), 8'h9e);
        run(hdr(8'h05, 8'h0, 8'h0c, 16'h0, 8'h0, 0), 8'h9e);
        run(hdr(8'h0, 8'h3, 8'h0c, 16'h0, 8'h0, 0), 8'h9e);
        run(hdr(8'h0, 8'h0, 8'h0e, 16'h0, 8'h0, 0), 8'h9e);
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0040, 8'h0, 0), 8'h9e);
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0200, 8'h0, 0), 8'h9e);
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0010, 8'h40, 0), 8'h9e);
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0018, 8'h0, 0), 8'h9d);
        run(hdr(8'h0, 8'h0, 8'h0c, 16'h0108, 8'h0, 0), 8'h9d);
        run(hdr(8'h1, 8'h1, 8'h0c, 16'h0010, 8'h0, 0), 8'h7e);
        b = hdr(8'h1, 8'h0, 8'h0c, 16'h0010, 8'h0, 0);
        repeat (32) b.push_back(8'ha5);
        run(b, 8'h7e);
        b[2] = 8'h01;
        b[3] = 8'h0d;
        run(b, 8'h00);
        rd(kpm_pkg::A_FREE, 32'h07);
        run(hdr(8'h1, 8'h2, 8'h0c, 16'h0010, 8'h0, 0), 8'h9d);
        run(hdr(8'h1, 8'h2, 8'h0d, 16'h0010, 8'h3f, 7),
            8'h00);
        run(hdr(8'h1, 8'h2, 8'h0d, 16'h0010, 8'h10, 0),
            8'h00);
        // Both done and error events were seen since the last clear
        rd(kpm_pkg::A_IRQ, 32'h03);
    endtask : t_bad
    task automatic t_freeze();
        logic [31:0] lim;
        lim = 32'h0000_0102;
        run(hdr(8'h3, 8'h0, 8'h0c, 16'h8010, 8'h0, lim), 8'h00);
        drain();
        run(hdr(8'h3, 8'h2, 8'h0c, 16'h0010, 8'h0, lim), 8'h9d);
        run(hdr(8'h3, 8'h2, 8'h0c, 16'h8010, 8'h0, 32'h0201_0000),
            8'h9d);
        run(hdr(8'h3, 8'h2, 8'h0c, 16'h8010, 8'h0, lim), 8'h00);
    endtask : t_freeze
    task automatic t_full();
        logic [31:0] r;
        mem_free <= 1'b0;
        run(hdr(8'h4, 8'h0, 8'h0c, 16'h0010, 8'h0, 0), 8'h0e);
        mem_free <= 1'b1;
        rd(kpm_pkg::A_FREE, 32'h0f);
        run(hdr(8'h4, 8'h2, 8'h0c, 16'h0010, 8'h0, 0), 8'h40);
        apb(1'b0, 8'h30, 32'h0, r);
        check(r, 32'h0);
        check(pslverr, 1'b0);
        // Count saturates at 255; the byte after that flags overflow
        apb(1'b1, kpm_pkg::A_IRQ, 32'h7, r);
        repeat (256) apb(1'b1, kpm_pkg::A_CMD, 32'h0, r);
        rd(kpm_pkg::A_IRQ, 32'h04);
        rd(kpm_pkg::A_RESP, 32'h1f);
    endtask : t_full
    // ======================================================
    // Clock, reset, sequence and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        mem_free = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_gen();
        t_bad();
        t_freeze();
        t_full();
        complete_run();
    end
    // About 2500 cycles expected; ten times that means a hang
    initial begin
        #250000;
        failures++;
        complete_run();
    end
endmodule : key_pair_manage_cmd_test
`default_nettype wire
